// File: converter_softstart_fault_sequencer.sv
// Soft-start, power-good and fault sequencer for a two-phase buck controller.
// Assumes comparator levels and voltage codes are synchronous to sys_clk;
// registers are reached over a classic Wishbone slave with 32-bit data.
`timescale 1ns/1ps
`default_nettype none
module converter_softstart_fault_sequencer #(
   parameter int PHASES = 2,
   parameter int HICCUP_TICKS = softstart_seq_pkg::HICCUP_TICKS_DEF
) (
   input wire logic sys_clk, // 250 MHz clock
   input wire logic reset, // Synchronous, active high
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [7:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o, // Wishbone acknowledge
   input wire logic ctrl_bias_por_ok, // Controller bias POR reached
   input wire logic level_enable_input, // Enable comparator result
   input wire logic driver_bias_supply, // Driver bias POR reached
   input wire logic reference_select_lo, // Reference select bit 0
   input wire logic reference_select_hi, // Reference select bit 1
   input wire logic [10:0] remote_sense_pos, // Remote sense positive code
   input wire logic [10:0] remote_sense_return, // Remote sense return code
   input wire logic [10:0] feedback_node, // Feedback node code
   input wire logic [10:0] local_output_sense, // Local output code
   input wire logic [10:0] diff_sense_out, // Remote sense amplifier output code
   input wire logic [10:0] droop_sense, // Load-line current sense code
   input wire logic [10:0] overcurrent_setpoint, // Overcurrent setpoint code
   output logic [PHASES-1:0] phase_drive_en, // Phase PWM driven, else high-Z
   output logic [PHASES-1:0] low_side_gate, // Force low-side gate high
   output logic [10:0] ramp_reference, // Present internal reference code
   output logic [5:0] sense_offset, // Remote-sense offset code
   output logic power_good_out_o, // Power-good pin output level
   output logic power_good_out_oe // Power-good pull-low enable
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   softstart_seq_pkg::seq_state_t state_reg, state_next;
   softstart_seq_pkg::fault_t fault_reg, fault_next;
   logic [15:0] div_reg, div_cnt_reg;
   logic tick_reg;
   logic [12:0] cnt_reg, cnt_next;
   logic [10:0] ref_reg, ref_next, target_reg;
   logic [5:0] ofs_reg, ofs_next;
   logic drives_on_reg, drives_on_next;
   logic [PHASES-1:0] drive_en_reg, ls_reg;
   logic pg_low_reg, ack_reg;
   logic [31:0] rdat_reg;

   function automatic logic [10:0] ref_of_select(input logic [1:0] sel);
      logic [10:0] v;
      v = softstart_seq_pkg::REF_0V60;
      if (sel == 2'h1) begin
         v = softstart_seq_pkg::REF_0V90;
      end else if (sel == 2'h2) begin
         v = softstart_seq_pkg::REF_1V20;
      end else if (sel == 2'h3) begin
         v = softstart_seq_pkg::REF_1V50;
      end
      return v;
   endfunction

   // ----------------------------------------
   // Switching tick divider
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div_cnt_reg <= 16'h0000;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= (div_cnt_reg == 16'h0000);
         if (div_cnt_reg == 16'h0000) begin
            div_cnt_reg <= div_reg - 16'h0001;
         end else begin
            div_cnt_reg <= div_cnt_reg - 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Comparators
   // ----------------------------------------
   wire logic enabled = ctrl_bias_por_ok & level_enable_input & driver_bias_supply;
   wire logic [10:0] vout = remote_sense_pos - remote_sense_return;
   wire logic in_soft_start = (state_reg == softstart_seq_pkg::ST_SS_DELAY)
      || (state_reg == softstart_seq_pkg::ST_SS_RAMP);
   wire logic [17:0] vout_pct = {7'h00, vout} * softstart_seq_pkg::PCT_FULL;
   wire logic [17:0] uv_trip = {7'h00, ref_reg} * softstart_seq_pkg::UV_TRIP_PCT;
   wire logic [17:0] uv_clear = {7'h00, ref_reg} * softstart_seq_pkg::UV_CLEAR_PCT;
   wire logic [10:0] ov_rel = ref_reg + softstart_seq_pkg::OV_ABOVE_REF;
   // Fixed floor guards the output while the reference is still low
   wire logic fixed_wins = in_soft_start
      && (softstart_seq_pkg::OV_FIXED_LEVEL > ov_rel);
   wire logic [10:0] ov_trip = fixed_wins ? softstart_seq_pkg::OV_FIXED_LEVEL : ov_rel;
   wire logic [10:0] ov_release = fault_reg.ov_fixed
      ? softstart_seq_pkg::OV_FIXED_LEVEL - softstart_seq_pkg::OV_HYST_FIXED
      : ov_rel - softstart_seq_pkg::OV_HYST_REL;
   wire logic [11:0] open_limit = {1'b0, diff_sense_out}
      + {1'b0, softstart_seq_pkg::OPEN_SENSE_MARGIN};
   wire logic sense_open = {1'b0, local_output_sense} > open_limit;
   wire logic oc_trip = droop_sense > overcurrent_setpoint;
   wire logic coarse_phase = cnt_reg < softstart_seq_pkg::COARSE_TICKS;
   wire logic coarse_step = coarse_phase && (cnt_reg[4:0] == 5'h1f);
   wire logic fine_step = !coarse_phase && (cnt_reg[3:0] == 4'hf);
   wire logic ofs_step = coarse_phase && (cnt_reg[3:0] == 4'hf) && (ofs_reg != 6'h00);
   wire logic [10:0] ramp_step = coarse_step ? softstart_seq_pkg::STEP_COARSE
      : (fine_step ? softstart_seq_pkg::STEP_FINE : 11'h000);
   wire logic [10:0] ramp_sum = ref_reg + ramp_step;
   wire logic [10:0] sel_target = ref_of_select({reference_select_hi, reference_select_lo});

   // ----------------------------------------
   // Fault flags
   // ----------------------------------------
   always_comb begin
      fault_next = fault_reg;
      fault_next.sense_open = sense_open;
      fault_next.overcurrent = oc_trip;
      if (state_reg == softstart_seq_pkg::ST_SHUTDOWN) begin
         fault_next.overvoltage = 1'b0;
         fault_next.ov_fixed = 1'b0;
         fault_next.undervoltage = 1'b0;
      end else begin
         if (!fault_reg.overvoltage && vout > ov_trip) begin
            fault_next.overvoltage = 1'b1;
            fault_next.ov_fixed = fixed_wins;
         end else if (fault_reg.overvoltage && vout < ov_release) begin
            fault_next.overvoltage = 1'b0;
            fault_next.ov_fixed = 1'b0;
         end
         if (vout_pct < uv_trip) begin
            fault_next.undervoltage = 1'b1;
         end else if (vout_pct > uv_clear) begin
            fault_next.undervoltage = 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      ref_next = ref_reg;
      ofs_next = ofs_reg;
      drives_on_next = drives_on_reg;
      if (!enabled) begin
         state_next = softstart_seq_pkg::ST_SHUTDOWN;
         cnt_next = 13'h0000;
         ref_next = 11'h000;
         ofs_next = 6'h00;
         drives_on_next = 1'b0;
      end else begin
         case (state_reg)
            softstart_seq_pkg::ST_SHUTDOWN, softstart_seq_pkg::ST_SENSE_OPEN: begin
               if (!sense_open) begin
                  state_next = softstart_seq_pkg::ST_SS_DELAY;
                  cnt_next = 13'h0000;
                  ref_next = 11'h000;
                  ofs_next = softstart_seq_pkg::SENSE_OFFSET_INIT;
                  drives_on_next = 1'b0;
               end
            end
            softstart_seq_pkg::ST_SS_DELAY: begin
               if (tick_reg) begin
                  cnt_next = cnt_reg + 13'h0001;
                  if (cnt_reg == softstart_seq_pkg::SS_DELAY_TICKS - 13'h0001) begin
                     state_next = softstart_seq_pkg::ST_SS_RAMP;
                     cnt_next = 13'h0000;
                  end
               end
            end
            softstart_seq_pkg::ST_SS_RAMP: begin
               if (feedback_node < ref_reg) begin
                  drives_on_next = 1'b1;
               end
               if (tick_reg) begin
                  cnt_next = cnt_reg + 13'h0001;
                  ref_next = ramp_sum;
                  if (ofs_step) begin
                     ofs_next = ofs_reg - 6'h01;
                  end
                  if (ramp_sum >= target_reg) begin
                     ref_next = target_reg;
                     state_next = softstart_seq_pkg::ST_RUN;
                     drives_on_next = 1'b1;
                  end
               end
            end
            softstart_seq_pkg::ST_HICCUP: begin
               if (tick_reg) begin
                  cnt_next = cnt_reg + 13'h0001;
                  if (cnt_reg == 13'(HICCUP_TICKS - 1)) begin
                     state_next = softstart_seq_pkg::ST_SS_DELAY;
                     cnt_next = 13'h0000;
                     ref_next = 11'h000;
                     ofs_next = softstart_seq_pkg::SENSE_OFFSET_INIT;
                  end
               end
            end
            default: begin
            end
         endcase
         if (state_reg != softstart_seq_pkg::ST_SHUTDOWN
               && state_reg != softstart_seq_pkg::ST_SENSE_OPEN && sense_open) begin
            state_next = softstart_seq_pkg::ST_SENSE_OPEN;
            drives_on_next = 1'b0;
            cnt_next = 13'h0000;
         end else if ((in_soft_start || state_reg == softstart_seq_pkg::ST_RUN) && oc_trip) begin
            state_next = softstart_seq_pkg::ST_HICCUP;
            drives_on_next = 1'b0;
            cnt_next = 13'h0000;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= softstart_seq_pkg::ST_SHUTDOWN;
         fault_reg <= '0;
         cnt_reg <= 13'h0000;
         ref_reg <= 11'h000;
         ofs_reg <= 6'h00;
         drives_on_reg <= 1'b0;
         target_reg <= softstart_seq_pkg::REF_0V60;
      end else begin
         state_reg <= state_next;
         fault_reg <= fault_next;
         cnt_reg <= cnt_next;
         ref_reg <= ref_next;
         ofs_reg <= ofs_next;
         drives_on_reg <= drives_on_next;
         if (state_next == softstart_seq_pkg::ST_SS_DELAY
               && state_reg != softstart_seq_pkg::ST_SS_DELAY) begin
            target_reg <= sel_target;
         end
      end
   end

   // ----------------------------------------
   // Phase drives and power-good
   // ----------------------------------------
   wire logic drives_allowed = drives_on_reg && (state_reg == softstart_seq_pkg::ST_SS_RAMP
      || state_reg == softstart_seq_pkg::ST_RUN);
   wire logic ov_clamp = fault_reg.overvoltage && (state_reg != softstart_seq_pkg::ST_SHUTDOWN);
   // Power-good only in regulation; overcurrent pulls it low directly, on the same edge as the state leaves run
   wire logic pg_low_next = (state_reg != softstart_seq_pkg::ST_RUN) || fault_reg.undervoltage
      || fault_reg.overvoltage || oc_trip;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         drive_en_reg <= '0;
         ls_reg <= '0;
         pg_low_reg <= 1'b1;
      end else begin
         drive_en_reg <= {PHASES{drives_allowed && !ov_clamp}};
         ls_reg <= {PHASES{ov_clamp}};
         pg_low_reg <= pg_low_next;
      end
   end

   // ----------------------------------------
   // Wishbone register slave
   // ----------------------------------------
   wire logic wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
   wire logic wr_ctrl = wb_req && wb_we_i && (wb_adr_i == softstart_seq_pkg::CTRL_OFS);
   wire logic [15:0] div_wdata = {wb_sel_i[1] ? wb_dat_i[15:8] : div_reg[15:8],
      wb_sel_i[0] ? wb_dat_i[7:0] : div_reg[7:0]};
   wire logic [31:0] status_word = {22'h000000, !pg_low_reg, drives_on_reg, fault_reg,
      state_reg};
   wire logic [31:0] refmon_word = {4'h0, target_reg, ofs_reg[4:0], ofs_reg[5], ref_reg};
   wire logic [31:0] rdata;
   assign rdata = (wb_adr_i == softstart_seq_pkg::CTRL_OFS) ? {16'h0000, div_reg}
      : (wb_adr_i == softstart_seq_pkg::STATUS_OFS) ? status_word
      : (wb_adr_i == softstart_seq_pkg::REFMON_OFS) ? refmon_word : 32'h00000000;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h00000000;
         div_reg <= softstart_seq_pkg::SW_DIV_RESET;
      end else begin
         ack_reg <= wb_req;
         if (wb_req && !wb_we_i) begin
            rdat_reg <= rdata;
         end
         if (wr_ctrl) begin
            // A zero divisor would wrap the counter to a 65536-clock tick, so it is held at one
            div_reg <= (div_wdata == 16'h0000) ? 16'h0001 : div_wdata;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   assign phase_drive_en = drive_en_reg;
   assign low_side_gate = ls_reg;
   assign ramp_reference = ref_reg;
   assign sense_offset = ofs_reg;
   assign power_good_out_o = 1'b0;
   assign power_good_out_oe = pg_low_reg;
endmodule
`default_nettype wire

// File: converter_softstart_fault_sequencer_bench.sv
// Self-checking bench for the soft-start and fault sequencer.
// Assumes Wishbone ack one cycle after a request, ticks every DIV clocks.
`timescale 1ns/1ps
`default_nettype none
module converter_softstart_fault_sequencer_bench;
   localparam int DIV = 4;
   logic sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, vout_force, pg_line;
   logic ctrl_bias_por_ok, level_enable_input, driver_bias_supply;
   logic reference_select_lo, reference_select_hi, power_good_out_o, power_good_out_oe;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [1:0] phase_drive_en, low_side_gate;
   logic [10:0] feedback_node, droop_sense, overcurrent_setpoint, vout_value, sense_extra;
   logic [10:0] ramp_reference, remote_sense_pos, remote_sense_return;
   logic [10:0] diff_sense_out, local_output_sense;
   logic [5:0] sense_offset;
   logic [10:0] vt[10] = '{11'h0be, 11'h0c8, 11'h0ce, 11'h12c, 11'h12d, 11'h11d, 11'h10e,
      11'h29d, 11'h280, 11'h272};
   logic [2:0] et[10] = '{3'h1, 3'h1, 3'h0, 3'h0, 3'h7, 3'h7, 3'h0, 3'h7, 3'h7, 3'h1};
   int errors, checks, n;
   converter_softstart_fault_sequencer #(.HICCUP_TICKS(8))
      u_converter_softstart_fault_sequencer (.*);
   power_stage_model u_power_stage_model (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge sys_clk);
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int w = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      do begin
         @(posedge sys_clk);
         w++;
      end while (wb_ack_o !== 1'b1 && w < 40);
      if (w >= 40) errors++;
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge sys_clk);
   endtask
   task automatic state_is(input logic [2:0] s);
      wb(1'b0, 8'h04, 32'h0);
      check(32'(rd[2:0]), 32'(s));
   endtask
   task automatic set_en(input logic [2:0] e);
      {driver_bias_supply, level_enable_input, ctrl_bias_por_ok} <= e;
   endtask
   task automatic wait_pg();
      n = 0;
      while (power_good_out_oe !== 1'b0 && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
   endtask
   task automatic note(input string t);
      $display("test %s done, errors %0d", t, errors);
   endtask
   task automatic start_up(input logic [1:0] s, input logic [10:0] fb, input logic [1:0] mid);
      int total = 832 + 384 * s;
      {reference_select_hi, reference_select_lo} <= s;
      feedback_node <= fb;
      @(posedge sys_clk);
      set_en(3'b111);
      tick(DIV * 60);
      check(32'(ramp_reference), 32'h0);
      tick(DIV * 324);
      check(32'(sense_offset >= 6'h13 && sense_offset <= 6'h15), 32'h1);
      check(32'(ramp_reference >= 11'h05a && ramp_reference <= 11'h06e), 32'h1);
      check(32'(phase_drive_en), 32'(mid));
      wait_pg();
      n = n + DIV * 384;
      check(32'(n >= DIV * total - 6 && n <= DIV * total + 8), 32'h1);
      check(32'(ramp_reference), 32'(240 + 120 * s));
      check(32'({sense_offset, phase_drive_en, pg_line}), 32'h7);
      state_is(3'h3);
   endtask
   task automatic shut();
      set_en(3'b000);
      tick(3);
      check(32'({phase_drive_en, power_good_out_oe, pg_line}), 32'h2);
      state_is(3'h0);
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      {errors, checks, n} = '0;
      {reset, wb_cyc_i, wb_stb_i, wb_we_i, vout_force} = 5'b10000;
      {wb_adr_i, wb_dat_i, wb_sel_i} = {8'h00, 32'h0, 4'hf};
      {ctrl_bias_por_ok, level_enable_input, driver_bias_supply} = 3'b000;
      {reference_select_lo, reference_select_hi} = 2'b00;
      {feedback_node, droop_sense, vout_value, sense_extra} = '0;
      overcurrent_setpoint = 11'h100;
      tick(10);
      reset <= 1'b0;
      tick(1);
      check(32'({phase_drive_en, low_side_gate, power_good_out_oe}), 32'h1);
      wb(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, 8'h00, 32'(DIV));
      for (int i = 0; i < 3; i++) begin
         set_en(3'b111 ^ 3'(1 << i));
         tick(20);
         state_is(3'h0);
      end
      set_en(3'b111);
      tick(600);
      shut();
      note("enable");
      for (int i = 0; i < 4; i++) begin
         start_up(2'(i), 11'h000, 2'h3);
         shut();
      end
      note("startup");
      start_up(2'h0, 11'h7ff, 2'h0);
      note("prebias");
      for (int i = 0; i < 10; i++) begin
         if (i == 7) begin
            shut();
            set_en(3'b111);
         end
         vout_value <= vt[i];
         vout_force <= 1'b1;
         tick(4);
         check(32'({low_side_gate, power_good_out_oe}), 32'(et[i]));
      end
      vout_force <= 1'b0;
      shut();
      note("thresholds");
      start_up(2'h0, 11'h000, 2'h3);
      sense_extra <= 11'h191;
      tick(4);
      state_is(3'h5);
      sense_extra <= 11'h000;
      tick(4);
      state_is(3'h1);
      wait_pg();
      check(32'(pg_line), 32'h1);
      note("open sense");
      droop_sense <= 11'h101;
      tick(4);
      check(32'({phase_drive_en, power_good_out_oe}), 32'h1);
      state_is(3'h4);
      droop_sense <= 11'h000;
      n = 0;
      do begin
         wb(1'b0, 8'h04, 32'h0);
         n++;
      end while (rd[2:0] == 3'h4 && n < 100);
      check(32'({rd[2:0], 1'b0} == 4'h2 && n >= 7 && n <= 13), 32'h1);
      droop_sense <= 11'h101;
      n = 0;
      do begin
         wb(1'b0, 8'h04, 32'h0);
         n++;
      end while (rd[2:0] != 3'h4 && n < 2000);
      check(32'(rd[2:0]), 32'h4);
      droop_sense <= 11'h000;
      shut();
      note("overcurrent");
      give_verdict();
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      errors++;
      give_verdict();
   end
endmodule
bind converter_softstart_fault_sequencer softstart_seq_properties #(.PHASES(PHASES))
   u_softstart_seq_properties (.*);
`default_nettype wire

// File: power_stage_model.sv
// Power stage and monitor model: the output follows the reference.
// Assumes the bench sets forced levels right after clock edges.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
   input wire logic [10:0] ramp_reference, // Reference
   input wire logic vout_force, // Use vout_value
   input wire logic [10:0] vout_value, // Forced output
   input wire logic [10:0] sense_extra, // Local rise
   input wire logic power_good_out_o, // Pin level
   input wire logic power_good_out_oe, // Pull-low
   output logic [10:0] remote_sense_pos, // Sense pos
   output logic [10:0] remote_sense_return, // Sense return
   output logic [10:0] diff_sense_out, // Diff sense
   output logic [10:0] local_output_sense, // Local sense
   output logic pg_line // Pulled-up wire
);
   // Ideal loop, no droop; a lifted local sense mimics an open line
   assign remote_sense_pos = vout_force ? vout_value : ramp_reference;
   assign remote_sense_return = 11'h000;
   assign diff_sense_out = remote_sense_pos;
   assign local_output_sense = remote_sense_pos + sense_extra;
   assign pg_line = power_good_out_oe ? power_good_out_o : 1'b1;
endmodule
`default_nettype wire

// File: softstart_seq_pkg.sv
// Constants, types and register map for the converter soft-start and fault sequencer.
// Assumes voltages arrive as digitised codes of 2.5 mV per unit, all synchronous to sys_clk.
`default_nettype none
package softstart_seq_pkg;
   // ----------------------------------------
   // Voltage codes, 2.5 mV per unit
   // ----------------------------------------
   localparam int VW = 11;
   localparam logic [10:0] REF_0V60 = 11'h0f0;
   localparam logic [10:0] REF_0V90 = 11'h168;
   localparam logic [10:0] REF_1V20 = 11'h1e0;
   localparam logic [10:0] REF_1V50 = 11'h258;
   localparam logic [10:0] STEP_COARSE = 11'h00a;   // 25 mV
   localparam logic [10:0] STEP_FINE = 11'h005;     // 12.5 mV
   localparam logic [5:0] SENSE_OFFSET_INIT = 6'h28; // 100 mV
   localparam logic [10:0] OV_ABOVE_REF = 11'h03c;  // 150 mV
   localparam logic [10:0] OV_FIXED_LEVEL = 11'h29c; // 1.67 V
   localparam logic [10:0] OV_HYST_REL = 11'h014;   // 50 mV
   localparam logic [10:0] OV_HYST_FIXED = 11'h028; // 100 mV
   localparam logic [10:0] OPEN_SENSE_MARGIN = 11'h190; // 1 V
   localparam logic [17:0] UV_TRIP_PCT = 18'h00052;  // 82 %
   localparam logic [17:0] UV_CLEAR_PCT = 18'h00055; // 85 %
   localparam logic [17:0] PCT_FULL = 18'h00064;     // 100 %
   // ----------------------------------------
   // Counts in switching cycles
   // ----------------------------------------
   localparam logic [12:0] SS_DELAY_TICKS = 13'h0040;  // 64
   localparam logic [12:0] COARSE_TICKS = 13'h0280;    // 640
   localparam int HICCUP_TICKS_DEF = 4096;
   localparam logic [15:0] SW_DIV_RESET = 16'h022c;     // 556 clocks, about 450 kHz
   // ----------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] REFMON_OFS = 8'h08;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_SHUTDOWN, ST_SS_DELAY, ST_SS_RAMP, ST_RUN, ST_HICCUP, ST_SENSE_OPEN
   } seq_state_t;
   typedef struct packed {
      logic sense_open;
      logic overcurrent;
      logic overvoltage;
      logic ov_fixed;
      logic undervoltage;
   } fault_t;
endpackage
`default_nettype wire

// File: softstart_seq_properties.sv
// Pin-level checks for the converter soft-start and fault sequencer.
// Assumes one sys_clk domain; bound into the design from the bench top.
`timescale 1ns/1ps
`default_nettype none
module softstart_seq_properties #(
   parameter int PHASES = 2
) (
   input wire logic sys_clk, // Clock
   input wire logic reset, // Sync reset
   input wire logic ctrl_bias_por_ok, // Bias POR
   input wire logic level_enable_input, // Enable
   input wire logic driver_bias_supply, // Driver POR
   input wire logic [10:0] remote_sense_pos, // Sense pos
   input wire logic [10:0] remote_sense_return, // Sense return
   input wire logic [10:0] local_output_sense, // Local sense
   input wire logic [10:0] diff_sense_out, // Diff sense
   input wire logic [10:0] droop_sense, // Current sense
   input wire logic [10:0] overcurrent_setpoint, // Current limit
   input wire logic [PHASES-1:0] phase_drive_en, // Drives
   input wire logic [PHASES-1:0] low_side_gate, // Clamp
   input wire logic [10:0] ramp_reference, // Reference
   input wire logic [5:0] sense_offset, // Offset
   input wire logic power_good_out_oe // Pull-low
);
   // ----------------------------------------
   // Comparator views
   // ----------------------------------------
   wire logic en_all;
   wire logic [11:0] vout;
   wire logic uv_low;
   wire logic ov_high;
   wire logic oc_hit;
   wire logic open_hit;
   assign en_all = ctrl_bias_por_ok & level_enable_input & driver_bias_supply;
   assign vout = {1'b0, remote_sense_pos} - {1'b0, remote_sense_return};
   assign uv_low = (18'(vout) * 18'h00064) < (18'(ramp_reference) * 18'h00052);
   // Above both levels, so a trip whatever phase the sequencer is in
   assign ov_high = (vout > 12'(ramp_reference) + 12'h03c) && (vout > 12'h29c);
   assign oc_hit = droop_sense > overcurrent_setpoint;
   assign open_hit = {1'b0, local_output_sense} > {1'b0, diff_sense_out} + 12'h190;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_shut_high_z: assert property (!en_all [*3]
         |-> phase_drive_en == '0 && low_side_gate == '0)
      else $error("drive active in shutdown");
   a_pg_on_disable: assert property ($fell(en_all) |-> ##2 power_good_out_oe)
      else $error("power good kept after disable");
   a_uv_pg_low: assert property ((en_all && uv_low) [*3] |=> power_good_out_oe)
      else $error("power good released in undervoltage");
   a_ov_clamp_on: assert property ((en_all && ov_high) [*3]
         |=> low_side_gate == '1 && power_good_out_oe)
      else $error("no clamp in overvoltage");
   a_oc_drive_off: assert property ((en_all && oc_hit) [*3]
         |=> phase_drive_en == '0 && power_good_out_oe)
      else $error("drive on in overcurrent");
   a_open_sense_off: assert property ((en_all && open_hit) [*3]
         |=> phase_drive_en == '0 && power_good_out_oe)
      else $error("drive on with open sense");
   a_drive_after_ramp: assert property ($rose(phase_drive_en[0]) |-> ramp_reference != 11'h000)
      else $error("drive before ramp");
   a_offset_start: assert property ($rose(en_all) |-> ##2 sense_offset == 6'h28)
      else $error("offset not loaded");
   a_offset_fall: assert property (!$stable(sense_offset) |-> sense_offset == $past(sense_offset) - 6'h01
         || sense_offset == 6'h28 || sense_offset == 6'h00)
      else $error("offset step wrong");
   a_ramp_step: assert property (!$stable(ramp_reference) |-> ramp_reference == 11'h000
         || ramp_reference - $past(ramp_reference) inside {11'h00a, 11'h005})
      else $error("reference step wrong");
   a_pg_release: assert property (!power_good_out_oe
         |-> phase_drive_en == '1 && sense_offset == 6'h00)
      else $error("power good before start done");
endmodule
`default_nettype wire
